/* File: plsc_pkg.sv */
// Package: offsets, field positions, reset values and timing for power/lock/sync control
package plsc_pkg;
    // Register byte offsets
    localparam logic [3:0] PLSC_OFS_POWER_CONTROL = 4'h0;
    localparam logic [3:0] PLSC_OFS_LOCK_KEY      = 4'h4;
    localparam logic [3:0] PLSC_OFS_INIT_SYNC     = 4'h8;
    localparam logic [3:0] PLSC_OFS_DEVICE_CFG    = 4'hC;
    localparam logic [3:0] PLSC_OFS_STATUS        = 4'h0 + 4'h0;
    // Init and sync control bit positions
    localparam int PLSC_BIT_CLEAR_GROUP1_OUT_ENABLE = 7;
    localparam int PLSC_BIT_CLEAR_GROUP0_OUT_ENABLE = 6;
    localparam int PLSC_BIT_ID_SET_N    = 5;
    localparam int PLSC_BIT_GOE         = 4;
    localparam int PLSC_BIT_GRP1_SYNC   = 3;
    localparam int PLSC_BIT_GRP0_SYNC   = 2;
    localparam int PLSC_BIT_ALL_SYNC    = 1;
    localparam int PLSC_BIT_APLL_REINIT = 0;
    // Device configuration field positions (sync wait code, pin select)
    localparam int PLSC_POS_WAIT_CODE = 0;
    localparam int PLSC_POS_PIN_SEL   = 4;
    // Reset values
    localparam logic       PLSC_RST_RESTORE_N  = 1'b1;
    localparam logic [7:0] PLSC_RST_LOCK_KEY   = 8'h00;
    localparam logic       PLSC_RST_ID_SET_N   = 1'b1;
    localparam logic       PLSC_RST_GOE        = 1'b1;
    localparam logic [3:0] PLSC_RST_WAIT_CODE  = 4'h2;
    localparam logic [3:0] PLSC_RST_PIN_SEL    = 4'hF;
    // Lock key values, disabled pin select code and maximum wait code
    localparam logic [7:0] PLSC_KEY_LOCK   = 8'hCB;
    localparam logic [7:0] PLSC_KEY_UNLOCK = 8'h34;
    localparam logic [3:0] PLSC_PIN_NONE   = 4'hF;
    localparam logic [3:0] PLSC_WAIT_MAX   = 4'hC;
    // Timing
    localparam int PLSC_CLK_MHZ       = 125;
    localparam int PLSC_WAIT_BASE_US  = 1;
    localparam int PLSC_WAIT_BASE_CYC = PLSC_WAIT_BASE_US * PLSC_CLK_MHZ;
    localparam int PLSC_STEP_CYC      = 16;
    // Startup step numbering handed to the startup engine
    localparam logic [1:0] PLSC_START_NONE  = 2'h0;
    localparam logic [1:0] PLSC_START_FULL  = 2'h1;
    localparam logic [1:0] PLSC_START_VCO   = 2'h2;
endpackage : plsc_pkg

/* File: plsc_wait_if.sv */
// Interface between the sequencer and its wait timer
`timescale 1ns/10ps
interface plsc_wait_if;
    logic       start;
    logic [3:0] code;
    logic       done;
    modport seq (output start, output code, input done);
    modport tmr (input start, input code, output done);
endinterface : plsc_wait_if

/* File: plsc_wait_timer.sv */
// Output-disable wait timer: 1 us doubled per code step
`timescale 1ns/10ps
module plsc_wait_timer
    import plsc_pkg::*;
#(
    parameter int BASE_CYC = PLSC_WAIT_BASE_CYC
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Sequencer side
    plsc_wait_if.tmr  w
);
    logic [31:0] cnt_q;
    logic        run_q;

    // Load 2^code microseconds on start, pulse done when it runs out
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q  <= 32'h0;
            run_q  <= 1'b0;
            w.done <= 1'b0;
        end else if (ce_i) begin
            w.done <= 1'b0;
            if (w.start) begin
                cnt_q <= 32'(BASE_CYC) << w.code;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (cnt_q <= 32'h1) begin
                    run_q  <= 1'b0;
                    w.done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 32'h1;
                end
            end
        end
    end
endmodule : plsc_wait_timer

/* File: plsc_power_lock_sync.sv */
// Power-down handling, configuration lock and divider sync control
// Behaviour
// - Restore setting resets to 1 and reset sequence returns it to 1.
// - Restore 0: pin falling edge fully resets device and runs startup.
// - Full mode: startup waits pin rise, re-latches select inputs, loads config.
// - Restore 1: pin fall loads power-down config, rise loads power-up config.
// - Quick mode: no startup run and no select re-latch on pin edges.
// - Lock key 0xCB sets write protect.
// - Lock key 0x34 clears write protect.
// - Bits 7 and 6 clear group output enable, self-clearing.
// - Group output enable returns only when that group's next sync completes.
// - Group enable gates every output in banks using that group.
// - Input-divider common set bit low holds all input dividers in set.
// - Bit 4 directly controls the global output enable.
// - Bit 3 starts group 1 divider sync, self-clearing.
// - Bit 2 starts group 0 divider sync, self-clearing.
// - Bit 1 starts sync of both groups, self-clearing.
// - Affected outputs squelched for about the programmed wait during sync; the sync after a bit 0 restart leaves them enabled.
// - Bit 0 restarts startup from VCO calibration with divider sync.
// - Sync waits programmed time after output disable; 1 us doubling codes.
// - Pin select picks power pin; startup waits high; code 0xF disables.
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
module plsc_power_lock_sync
    import plsc_pkg::*;
#(
    parameter int NUM_PINS  = 9,
    parameter int NUM_BANKS = 8,
    parameter int BASE_CYC  = PLSC_WAIT_BASE_CYC
) (
    // Clock, reset, enable
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    // Wishbone slave
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [3:0]           adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    output logic      [31:0]          dat_o,
    output logic                      ack_o,
    // Pins and bank group map
    input  wire logic [NUM_PINS-1:0]  gpio_pins_i,
    input  wire logic [NUM_BANKS-1:0] bank_group1_i,
    // Startup engine handshake
    input  wire logic                 startup_done_i,
    // Control outputs
    output logic                      full_reset_o,
    output logic [1:0]                startup_from_o,
    output logic                      csel_latch_o,
    output logic                      load_power_down_o,
    output logic                      load_power_up_o,
    output logic                      sync_group0_o,
    output logic                      sync_group1_o,
    output logic [NUM_BANKS-1:0]      bank_out_enable_o,
    output logic                      global_out_enable_o,
    output logic                      input_div_set_o,
    output logic                      config_write_protect_o
);
    typedef enum logic [3:0] {
        SQ_IDLE  = 4'b0001,
        SQ_WAIT  = 4'b0010,
        SQ_SYNC  = 4'b0100,
        SQ_START = 4'b1000
    } plsc_seq_type;

    // Pin synchroniser and edge detection
    logic [NUM_PINS-1:0] pin_s1_q;
    logic [NUM_PINS-1:0] pin_s2_q;
    logic                pwr_q;
    logic                pwr_d;
    logic                pwr_fall;
    logic                pwr_rise;

    // Registers
    logic                power_down_restore_n_q;
    logic [7:0]          lock_key_q;
    logic                config_write_protect_q;
    logic                input_divider_common_set_n_q;
    logic                goe_q;
    logic [3:0]          wait_code_q;
    logic [3:0]          pin_sel_q;
    logic [1:0]          grp_oe_q;
    logic                wait_full_q;
    logic                wr;
    logic                rd_ack;
    logic [7:0]          wbyte;

    // Sequencer
    plsc_seq_type        seq_q;
    logic [1:0]          sync_grp_q;
    logic [1:0]          sync_req;
    logic                reinit;
    plsc_wait_if         wt ();

    // Byte write helper
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        return a == ofs;
    endfunction : hit

    assign wr    = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    assign wbyte = dat_i[7:0];
    assign rd_ack = cyc_i && stb_i && !ack_o;

    // Two-stage pin synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else if (ce_i) begin
            pin_s1_q <= gpio_pins_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Selected power pin; disabled selection reads as high
    always_comb begin
        if (pin_sel_q == PLSC_PIN_NONE || int'(pin_sel_q) >= NUM_PINS) begin
            pwr_d = 1'b1;
        end else begin
            pwr_d = pin_s2_q[pin_sel_q];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_q <= 1'b1;
        end else if (ce_i) begin
            pwr_q <= pwr_d;
        end
    end

    assign pwr_fall = pwr_q && !pwr_d;
    assign pwr_rise = !pwr_q && pwr_d;

    // Power control register; a full reset returns restore to 1
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_down_restore_n_q <= PLSC_RST_RESTORE_N;
        end else if (ce_i) begin
            if (full_reset_o) begin
                power_down_restore_n_q <= PLSC_RST_RESTORE_N;
            end else if (wr && hit(adr_i, PLSC_OFS_POWER_CONTROL) && !config_write_protect_q) begin
                power_down_restore_n_q <= wbyte[0];
            end
        end
    end

    // Lock key and write protect, always writable
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && full_reset_o)) begin
            lock_key_q             <= PLSC_RST_LOCK_KEY;
            config_write_protect_q <= 1'b0;
        end else if (ce_i && wr && hit(adr_i, PLSC_OFS_LOCK_KEY)) begin
            lock_key_q <= wbyte;
            if (wbyte == PLSC_KEY_LOCK) begin
                config_write_protect_q <= 1'b1;
            end else if (wbyte == PLSC_KEY_UNLOCK) begin
                config_write_protect_q <= 1'b0;
            end
        end
    end

    // Init/sync level bits and device configuration fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            input_divider_common_set_n_q <= PLSC_RST_ID_SET_N;
            goe_q                        <= PLSC_RST_GOE;
            wait_code_q                  <= PLSC_RST_WAIT_CODE;
            pin_sel_q                    <= PLSC_RST_PIN_SEL;
        end else if (ce_i && full_reset_o) begin // Pin select kept so startup waits for the pin
            input_divider_common_set_n_q <= PLSC_RST_ID_SET_N;
            goe_q                        <= PLSC_RST_GOE;
            wait_code_q                  <= PLSC_RST_WAIT_CODE;
        end else if (ce_i && wr && !config_write_protect_q) begin
            if (hit(adr_i, PLSC_OFS_INIT_SYNC)) begin
                input_divider_common_set_n_q <= wbyte[PLSC_BIT_ID_SET_N];
                goe_q                        <= wbyte[PLSC_BIT_GOE];
            end
            if (hit(adr_i, PLSC_OFS_DEVICE_CFG)) begin
                wait_code_q <= (wbyte[3:0] > PLSC_WAIT_MAX) ? PLSC_WAIT_MAX : wbyte[3:0];
                pin_sel_q   <= wbyte[PLSC_POS_PIN_SEL +: 4];
            end
        end
    end

    // Self-clearing triggers: act for one cycle, never stored
    assign sync_req[1] = wr && !config_write_protect_q && hit(adr_i, PLSC_OFS_INIT_SYNC)
                         && (wbyte[PLSC_BIT_GRP1_SYNC] || wbyte[PLSC_BIT_ALL_SYNC]);
    assign sync_req[0] = wr && !config_write_protect_q && hit(adr_i, PLSC_OFS_INIT_SYNC)
                         && (wbyte[PLSC_BIT_GRP0_SYNC] || wbyte[PLSC_BIT_ALL_SYNC]);
    assign reinit      = wr && !config_write_protect_q && hit(adr_i, PLSC_OFS_INIT_SYNC)
                         && wbyte[PLSC_BIT_APLL_REINIT];

    // Group output enables: clear by software, set on that group's sync end
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && full_reset_o)) begin
            grp_oe_q <= 2'b11;
        end else if (ce_i) begin
            for (int g = 0; g < 2; g++) begin
                if (seq_q == SQ_SYNC && sync_grp_q[g]) begin
                    grp_oe_q[g] <= 1'b1;
                end else if (seq_q == SQ_IDLE && sync_req[g]) begin
                    grp_oe_q[g] <= 1'b0;
                end else if (wr && !config_write_protect_q && hit(adr_i, PLSC_OFS_INIT_SYNC)
                             && wbyte[g == 1 ? PLSC_BIT_CLEAR_GROUP1_OUT_ENABLE : PLSC_BIT_CLEAR_GROUP0_OUT_ENABLE]) begin
                    grp_oe_q[g] <= 1'b0;
                end
            end
        end
    end

    // Sync and startup sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_q          <= SQ_IDLE;
            sync_grp_q     <= 2'b00;
            wait_full_q    <= 1'b0;
            startup_from_o <= PLSC_START_NONE;
            full_reset_o   <= 1'b0;
            csel_latch_o   <= 1'b0;
            sync_group0_o  <= 1'b0;
            sync_group1_o  <= 1'b0;
        end else if (ce_i) begin
            full_reset_o   <= 1'b0;
            csel_latch_o   <= 1'b0;
            sync_group0_o  <= 1'b0;
            sync_group1_o  <= 1'b0;
            startup_from_o <= PLSC_START_NONE;
            if (pwr_fall && !power_down_restore_n_q) begin
                full_reset_o <= 1'b1;
                wait_full_q  <= 1'b1;
                seq_q        <= SQ_IDLE;
                sync_grp_q   <= 2'b00;
            end else if (wait_full_q) begin
                if (pwr_rise) begin
                    wait_full_q    <= 1'b0;
                    csel_latch_o   <= 1'b1;
                    startup_from_o <= PLSC_START_FULL;
                    seq_q          <= SQ_START;
                end
            end else begin
                unique case (seq_q)
                    SQ_IDLE: begin
                        if (reinit) begin
                            startup_from_o <= PLSC_START_VCO;
                            sync_grp_q     <= 2'b11;
                            seq_q          <= SQ_START;
                        end else if (sync_req != 2'b00) begin
                            sync_grp_q <= sync_req;
                            seq_q      <= SQ_WAIT;
                        end
                    end
                    SQ_WAIT: begin
                        if (wt.done) begin
                            sync_group0_o <= sync_grp_q[0];
                            sync_group1_o <= sync_grp_q[1];
                            seq_q         <= SQ_SYNC;
                        end
                    end
                    SQ_SYNC: begin
                        sync_grp_q <= 2'b00;
                        seq_q      <= SQ_IDLE;
                    end
                    SQ_START: begin
                        if (startup_done_i) begin
                            seq_q <= (sync_grp_q != 2'b00) ? SQ_WAIT : SQ_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Timer starts when the sequencer enters the wait
    assign wt.start = (seq_q == SQ_IDLE && !wait_full_q && !reinit && sync_req != 2'b00
                       && !(pwr_fall && !power_down_restore_n_q))
                      || (seq_q == SQ_START && startup_done_i && sync_grp_q != 2'b00 && !wait_full_q);
    assign wt.code  = wait_code_q;

    plsc_wait_timer #(
        .BASE_CYC (BASE_CYC)
    ) u_wait (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .w     (wt)
    );

    // Quick power-down and power-up loads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_power_down_o <= 1'b0;
            load_power_up_o   <= 1'b0;
        end else if (ce_i) begin
            load_power_down_o <= pwr_fall && power_down_restore_n_q;
            load_power_up_o   <= pwr_rise && power_down_restore_n_q && !wait_full_q;
        end
    end

    // Static control outputs and bank gating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_out_enable_o      <= '0;
            global_out_enable_o    <= 1'b0;
            input_div_set_o        <= 1'b0;
            config_write_protect_o <= 1'b0;
        end else if (ce_i) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                bank_out_enable_o[b] <= bank_group1_i[b] ? grp_oe_q[1] : grp_oe_q[0];
            end
            global_out_enable_o    <= goe_q;
            input_div_set_o        <= !input_divider_common_set_n_q;
            config_write_protect_o <= config_write_protect_q;
        end
    end

    // Wishbone answer: one cycle ack, zero for unmapped addresses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else if (ce_i) begin
            ack_o <= rd_ack;
            dat_o <= 32'h0;
            if (rd_ack && !we_i) begin
                unique case (adr_i)
                    PLSC_OFS_POWER_CONTROL: dat_o <= {31'h0, power_down_restore_n_q};
                    PLSC_OFS_LOCK_KEY:      dat_o <= {23'h0, config_write_protect_q, lock_key_q};
                    PLSC_OFS_INIT_SYNC:     dat_o <= {22'h0, grp_oe_q, 2'b00, input_divider_common_set_n_q,
                                                      goe_q, 4'h0};
                    PLSC_OFS_DEVICE_CFG:    dat_o <= {24'h0, pin_sel_q, wait_code_q};
                    default:                dat_o <= 32'h0;
                endcase
            end
        end
    end

    // Assertions
    sequence lock_write_s;
        ce_i && wr && hit(adr_i, PLSC_OFS_LOCK_KEY) && wbyte == PLSC_KEY_LOCK && !full_reset_o;
    endsequence
    lock_key_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        lock_write_s |=> config_write_protect_q) else $error("lock key did not protect");
    unlock_key_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr && hit(adr_i, PLSC_OFS_LOCK_KEY) && wbyte == PLSC_KEY_UNLOCK && !full_reset_o
        |=> !config_write_protect_q) else $error("unlock key did not clear");
    restore_back_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && full_reset_o |=> power_down_restore_n_q) else $error("restore not returned to one");
    full_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && pwr_fall && !power_down_restore_n_q |=> full_reset_o) else $error("no full reset");
    quick_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && pwr_fall && power_down_restore_n_q |=> load_power_down_o && !full_reset_o)
        else $error("quick power down mishandled");
    oe_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr && !config_write_protect_q && hit(adr_i, PLSC_OFS_INIT_SYNC) && wbyte[PLSC_BIT_CLEAR_GROUP0_OUT_ENABLE]
        && seq_q != SQ_SYNC && !full_reset_o |=> !grp_oe_q[0]) else $error("group 0 enable not cleared");
    oe_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !grp_oe_q[1] && !(seq_q == SQ_SYNC && sync_grp_q[1]) && !full_reset_o
        |=> !grp_oe_q[1]) else $error("group 1 enable set without sync");
    goe_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i && ce_i ##1 ce_i |-> global_out_enable_o == $past(goe_q)) else $error("global enable mismatch");
    protect_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && config_write_protect_q && !full_reset_o |=> $stable(goe_q))
        else $error("protected write took effect");
endmodule : plsc_power_lock_sync

/* File: tb_top.sv */
// Self-checking bench for power, lock and sync control
`timescale 1ns/10ps
module tb_top;
    import plsc_pkg::*;
    // Stimulus and observed signals
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, startup_done_i;
    logic [3:0]  adr_i;
    logic [31:0] dat_i, dat_o, rd;
    logic        ack_o, full_reset_o, csel_latch_o, load_power_down_o, load_power_up_o;
    logic        sync_group0_o, sync_group1_o, global_out_enable_o, input_div_set_o, config_write_protect_o;
    logic [1:0]  startup_from_o;
    logic [8:0]  gpio_pins_i;
    logic [7:0]  bank_out_enable_o, pulses;
    int          mismatches, checks_done, cycles;
    int          c[8], s[8];
    typedef struct {logic w; logic [3:0] a; logic [31:0] d; logic [31:0] e;} tb_row_type;
    tb_row_type  rows[14];

    plsc_power_lock_sync #(.BASE_CYC(2)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .gpio_pins_i(gpio_pins_i), .bank_group1_i(8'hF0), .startup_done_i(startup_done_i),
        .full_reset_o(full_reset_o), .startup_from_o(startup_from_o), .csel_latch_o(csel_latch_o),
        .load_power_down_o(load_power_down_o), .load_power_up_o(load_power_up_o),
        .sync_group0_o(sync_group0_o), .sync_group1_o(sync_group1_o),
        .bank_out_enable_o(bank_out_enable_o), .global_out_enable_o(global_out_enable_o),
        .input_div_set_o(input_div_set_o), .config_write_protect_o(config_write_protect_o)
    );

    // Clock at 125 MHz
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Pulse counters for the control outputs
    assign pulses = {startup_from_o == 2'h2, startup_from_o == 2'h1, csel_latch_o, load_power_up_o,
                     load_power_down_o, full_reset_o, sync_group1_o, sync_group0_o};
    always @(posedge clk_i) begin
        for (int i = 0; i < 8; i++) if (pulses[i] === 1'b1) c[i]++;
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    // Compare and report
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Pulse count since last snapshot
    task dchk(input int k, input int e);
        chk(32'(c[k] - s[k]), 32'(e));
    endtask : dchk

    // Classic Wishbone single cycle
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
        if (n >= 50) mismatches++;
        s = c;
    endtask : wb

    // Wait then compare a read
    task rdchk(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk

    // Drive a pin and wait for the response
    task pin(input logic v);
        @(posedge clk_i);
        gpio_pins_i[0] <= v;
        s = c;
        repeat (12) @(posedge clk_i);
    endtask : pin

    // Verdict
    task complete_run();
        $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run

    initial begin
        {cyc_i, stb_i, we_i, startup_done_i, adr_i, dat_i} = '0;
        gpio_pins_i = 9'h1FF;
        rst_i = 1'b1;
        rows = '{'{0, 4'h0, 0, 32'h1},   '{0, 4'h4, 0, 32'h0},   '{0, 4'h8, 0, 32'h330},
                 '{0, 4'hC, 0, 32'hF2},  '{0, 4'h2, 0, 32'h0},   '{1, 4'h4, 32'hCB, 0},
                 '{0, 4'h4, 0, 32'h1CB}, '{1, 4'h8, 32'h00, 0},  '{0, 4'h8, 0, 32'h330},
                 '{1, 4'hC, 32'h00, 0},  '{0, 4'hC, 0, 32'hF2},  '{1, 4'h4, 32'h34, 0},
                 '{0, 4'h4, 0, 32'h34},  '{1, 4'hC, 32'hF0, 0}};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, lock key, protection, unmapped read
        foreach (rows[i]) begin
            wb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].e);
        end
        // Common set and global enable
        wb(1'b1, 4'h8, 32'h00);
        @(negedge clk_i);
        chk(32'({input_div_set_o, global_out_enable_o}), 32'h2);
        wb(1'b1, 4'h8, 32'h30);
        @(negedge clk_i);
        chk(32'({input_div_set_o, global_out_enable_o}), 32'h1);
        // Clear group 0, a group 1 sync must not restore it
        wb(1'b1, 4'h8, 32'h70);
        repeat (3) @(posedge clk_i);
        chk(32'(bank_out_enable_o), 32'hF0);
        rdchk(4'h8, 32'h230);
        wb(1'b1, 4'h8, 32'h38);
        repeat (40) @(posedge clk_i);
        dchk(1, 1);
        dchk(0, 0);
        rdchk(4'h8, 32'h230);
        wb(1'b1, 4'h8, 32'h34);
        repeat (40) @(posedge clk_i);
        dchk(0, 1);
        dchk(1, 0);
        rdchk(4'h8, 32'h330);
        chk(32'(bank_out_enable_o), 32'hFF);
        // Both groups, then reinit from VCO calibration
        wb(1'b1, 4'h8, 32'h32);
        repeat (40) @(posedge clk_i);
        dchk(0, 1);
        dchk(1, 1);
        wb(1'b1, 4'h8, 32'h31);
        repeat (5) @(posedge clk_i);
        dchk(7, 1);
        startup_done_i <= 1'b1;
        repeat (40) @(posedge clk_i);
        startup_done_i <= 1'b0;
        dchk(0, 1);
        dchk(1, 1);
        // Quick power down and up on pin 0
        wb(1'b1, 4'hC, 32'h00);
        pin(1'b0);
        dchk(3, 1);
        dchk(2, 0);
        dchk(5, 0);
        dchk(6, 0);
        pin(1'b1);
        dchk(4, 1);
        dchk(5, 0);
        dchk(6, 0);
        dchk(2, 0);
        // Full power-on reset mode
        wb(1'b1, 4'h0, 32'h00);
        rdchk(4'h0, 32'h0);
        pin(1'b0);
        dchk(2, 1);
        rdchk(4'h0, 32'h1);
        pin(1'b1);
        dchk(5, 1);
        dchk(6, 1);
        startup_done_i <= 1'b1;
        @(posedge clk_i);
        startup_done_i <= 1'b0;
        // Reset in mid-run clears the lock
        wb(1'b1, 4'h4, 32'hCB);
        @(negedge clk_i);
        chk(32'(config_write_protect_o), 32'h1);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(4'h4, 32'h0);
        @(negedge clk_i);
        chk(32'(config_write_protect_o), 32'h0);
        complete_run();
    end
endmodule : tb_top
